/* File: hw/hb_seq_params.svh */
// Functional notes
// [R1] Mode 00 holds both gates actively off.
// [R2] Mode 01 turns low side on, high off.
// [R3] Mode 10 turns high side on, low off.
// [R4] Reserved mode 11 behaves as off.
// [R5] Unmapped half-bridge is activated statically, no modulation.
// [R6] Mode control only when not passive and enabled.
// [R7] Hard-off sink equals discharge code 31.
// [R8] Four-bit static code selects gate current level.
// [R9] Hold select picks hold level code.
// [R10] Faults in active mode discharge at static current.
// [R11] From 01 to 10: guard time first.
// [R12] Then charge, opposite hard-off, blank plus filter.
// [R13] After filter time, both drives go to hold.
// [R14] From 00 to 10: skip guard, charge immediately.
// [R15] Mode command applied within 3 us.
// [R16] Low side sequences mirror high side ones.
// [R17] Off write: discharge for guard, then hold.
// [R18] Reset leaves passive set, all modes 00.
// [R19] Phase intervals are counters from per-bridge values.
`ifndef HB_SEQ_PARAMS_SVH
`define HB_SEQ_PARAMS_SVH
`define HB_COUNT 4
`define ADDR_CTRL 8'h00
`define ADDR_MODE 8'h04
`define ADDR_STICHG 8'h08
`define ADDR_PWMMAP 8'h0C
`define ADDR_TIM0 8'h10
`define ADDR_TIM1 8'h14
`define ADDR_TIM2 8'h18
`define ADDR_TIM3 8'h1C
`define ADDR_STATUS 8'h20
`define CTRL_PASSIVE_BIT 0
`define CTRL_HOLD_BIT 1
`define CTRL_OVERCURRENT_SHUTDOWN_ENABLE_BIT 2
`define CTRL_RESET 3'h1
`define MODE_RESET 8'h00
`define MODE_OFF 2'h0
`define MODE_LOW 2'h1
`define MODE_HIGH 2'h2
`define MODE_RSVD 2'h3
`define STICHG_RESET 16'h0000
`define PWMMAP_RESET 4'h0
`define TIM_RESET 24'h000000
`define CODE_HARD_OFF 5'h1F
`define CODE_HOLD_LO 5'h04
`define CODE_HOLD_HI 5'h06
`define CLK_MHZ 40
`define CMD_DELAY_NS 3000
`define CMD_DELAY_CYC ((`CMD_DELAY_NS * `CLK_MHZ) / 1000)
`endif

/* File: hw/hb_seq_pkg.sv */
package hb_seq_pkg;
  typedef enum logic [2:0] {
    GD_PASSIVE, GD_CHG_ST, GD_DCHG_ST, GD_HARD_OFF, GD_HOLD_ON, GD_HOLD_OFF, GD_PWM
  } drive_kind_t;
  typedef struct packed {
    drive_kind_t kind;
    logic [4:0] code;
  } gate_drive_t;
  typedef enum logic [2:0] {
    PH_PASSIVE, PH_OFF_GUARD, PH_OFF, PH_GUARD, PH_CHARGE, PH_HOLD, PH_FAULT, PH_PWM
  } phase_t;
  typedef struct packed {
    logic supply;
    logic temp;
    logic vds;
    logic cpump;
    logic ocur;
  } fault_t;
  typedef struct packed {
    logic [7:0] filter;
    logic [7:0] blank;
    logic [7:0] guard;
  } timing_t;
endpackage : hb_seq_pkg

/* File: hw/half_bridge_static_gate_sequencer.sv */
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "hb_seq_params.svh"
module half_bridge_static_gate_sequencer (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enable_in,
  input wire hb_seq_pkg::fault_t faults,
  output hb_seq_pkg::gate_drive_t [3:0] high_side_switch,
  output hb_seq_pkg::gate_drive_t [3:0] low_side_switch
);
  import hb_seq_pkg::*;

  // Longest allowed gap from a mode write to its use, in clock cycles. The
  // sequencer needs only one, so this bound serves the timing check below.
  localparam int APPLY_MAX = `CMD_DELAY_CYC;

  // Software-visible configuration and the per-bridge sequencer state.
  logic [2:0] ctrl;
  logic [7:0] half_bridge_mode_reg;
  logic [7:0] applied_mode;
  logic [15:0] static_current_reg;
  logic [3:0] pwm_channel_setup;
  timing_t [3:0] timing;
  logic [3:0] apply;
  logic [3:0] on_prev;
  logic [3:0] side_prev;
  phase_t [3:0] phase;
  logic [8:0] cnt [4];
  logic bridge_passive_ctl;
  logic hold_current_sel;
  logic overcurrent_shutdown_enable;
  logic active;
  logic fault_hit;
  logic wr_en;
  logic mode_wr;

  // Mode field of one half-bridge out of a packed mode word.
  function automatic logic [1:0] hb_mode(input logic [7:0] word, input int idx);
    hb_mode = word[idx*2 +: 2];
  endfunction : hb_mode

  // Only 01 and 10 switch a side on; 00 and 11 both mean off.
  function automatic logic mode_on(input logic [1:0] m);
    mode_on = (m == `MODE_LOW) || (m == `MODE_HIGH);
  endfunction : mode_on

  // Drive pair for one half-bridge, written for the switch being turned on
  // and then swapped so the low side mirrors the high side.
  function automatic logic [15:0] drive_pair(input phase_t ph, input logic hi,
                                             input logic [3:0] sc, input logic hsel);
    gate_drive_t on_d;
    gate_drive_t opp_d;
    gate_drive_t st_c;
    gate_drive_t st_d;
    gate_drive_t h_on;
    gate_drive_t h_off;
    st_c = '{kind: GD_CHG_ST, code: {1'b0, sc}}; // R8
    st_d = '{kind: GD_DCHG_ST, code: {1'b0, sc}}; // R8
    h_on = '{kind: GD_HOLD_ON, code: hsel ? `CODE_HOLD_HI : `CODE_HOLD_LO}; // R9
    h_off = '{kind: GD_HOLD_OFF, code: hsel ? `CODE_HOLD_HI : `CODE_HOLD_LO}; // R9
    on_d = '{kind: GD_PASSIVE, code: 5'h00};
    opp_d = '{kind: GD_PASSIVE, code: 5'h00};
    unique case (ph)
      PH_PASSIVE: begin
      end
      PH_OFF_GUARD, PH_FAULT: begin
        on_d = st_d; // R10
        opp_d = st_d; // R17
      end
      PH_OFF: begin
        on_d = h_off; // R1
        opp_d = h_off; // R4
      end
      PH_GUARD: begin
        on_d = st_d; // R11
        opp_d = st_d; // R11
      end
      PH_CHARGE: begin
        on_d = st_c; // R12
        opp_d = '{kind: GD_HARD_OFF, code: `CODE_HARD_OFF}; // R7
      end
      PH_HOLD: begin
        on_d = h_on; // R13
        opp_d = h_off; // R13
      end
      PH_PWM: begin
        // Modulation lives outside this block; the drive is only marked as owned.
        on_d = '{kind: GD_PWM, code: {1'b0, sc}};
        opp_d = '{kind: GD_PWM, code: {1'b0, sc}};
      end
    endcase
    // High side selected is mode 10, low side mode 01 with roles exchanged.
    drive_pair = hi ? {on_d, opp_d} : {opp_d, on_d}; // R2 R3 R16
  endfunction : drive_pair

  assign bridge_passive_ctl = ctrl[`CTRL_PASSIVE_BIT];
  assign hold_current_sel = ctrl[`CTRL_HOLD_BIT];
  assign overcurrent_shutdown_enable = ctrl[`CTRL_OVERCURRENT_SHUTDOWN_ENABLE_BIT];
  assign wr_en = psel && penable && pwrite && pready;
  assign mode_wr = wr_en && (paddr == `ADDR_MODE);

  // Gate control runs only when software has left passive and the pin is high.
  assign active = enable_in && !bridge_passive_ctl; // R6

  // Overcurrent only counts when its shutdown enable is set.
  assign fault_hit = active && (faults.supply || faults.temp || faults.vds ||
                                faults.cpump || (faults.ocur && overcurrent_shutdown_enable)); // R10

  // Register writes land on the access edge only.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= `CTRL_RESET; // R18
      half_bridge_mode_reg <= `MODE_RESET; // R18
      static_current_reg <= `STICHG_RESET;
      pwm_channel_setup <= `PWMMAP_RESET;
      timing <= {`TIM_RESET, `TIM_RESET, `TIM_RESET, `TIM_RESET};
    end else if (wr_en) begin
      unique case (paddr)
        `ADDR_CTRL: ctrl <= pwdata[2:0];
        `ADDR_MODE: half_bridge_mode_reg <= pwdata[7:0];
        `ADDR_STICHG: static_current_reg <= pwdata[15:0];
        `ADDR_PWMMAP: pwm_channel_setup <= pwdata[3:0];
        `ADDR_TIM0: timing[0] <= pwdata[23:0];
        `ADDR_TIM1: timing[1] <= pwdata[23:0];
        `ADDR_TIM2: timing[2] <= pwdata[23:0];
        `ADDR_TIM3: timing[3] <= pwdata[23:0];
        default: begin
        end
      endcase
    end
  end

  // Zero-wait APB answer; read data and error are set up in the setup cycle
  // so that every bus output comes from a flop.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !((paddr[1:0] == 2'h0) && (paddr <= `ADDR_STATUS));
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `ADDR_CTRL: prdata <= {29'h0, ctrl};
          `ADDR_MODE: prdata <= {24'h0, half_bridge_mode_reg};
          `ADDR_STICHG: prdata <= {16'h0, static_current_reg};
          `ADDR_PWMMAP: prdata <= {28'h0, pwm_channel_setup};
          `ADDR_TIM0: prdata <= {8'h0, timing[0]};
          `ADDR_TIM1: prdata <= {8'h0, timing[1]};
          `ADDR_TIM2: prdata <= {8'h0, timing[2]};
          `ADDR_TIM3: prdata <= {8'h0, timing[3]};
          `ADDR_STATUS: prdata <= {18'h0, fault_hit, active, phase};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // A mode write is taken over one cycle after the access, well inside the
  // allowed command delay; every field is re-applied, but one that keeps its on-side keeps its phase.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      apply <= 4'h0;
      applied_mode <= `MODE_RESET;
    end else begin
      apply <= {4{mode_wr}}; // R15
      if (mode_wr) begin
        applied_mode <= pwdata[7:0]; // R15
      end
    end
  end

  // Per-bridge phase sequencer with one down counter per bridge, reloaded for each timed phase.
  // A restart from passive or fault never enters PH_GUARD, since nothing
  // was driven on before.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `HB_COUNT; i++) begin
        phase[i] <= PH_PASSIVE;
        cnt[i] <= 9'h000;
      end
      on_prev <= 4'h0;
      side_prev <= 4'h0;
    end else begin
      for (int i = 0; i < `HB_COUNT; i++) begin
        logic [1:0] m;
        logic restart;
        m = hb_mode(applied_mode, i);
        restart = (phase[i] == PH_PASSIVE) || (phase[i] == PH_FAULT);
        if (!active) begin
          phase[i] <= PH_PASSIVE; // R6
          on_prev[i] <= 1'b0;
        end else if (fault_hit) begin
          // A fault wins over a pending mode write, so the gates drop first.
          phase[i] <= PH_FAULT; // R10
          on_prev[i] <= 1'b0;
        end else if (apply[i] || restart) begin
          if (!mode_on(m)) begin
            phase[i] <= PH_OFF_GUARD; // R17
            cnt[i] <= {1'b0, timing[i].guard}; // R19
            on_prev[i] <= 1'b0;
          end else if (pwm_channel_setup[i]) begin
            phase[i] <= PH_PWM;
            on_prev[i] <= 1'b1;
            side_prev[i] <= m[1];
          end else if (on_prev[i] && (side_prev[i] == m[1])) begin
            phase[i] <= phase[i];
          end else if (on_prev[i]) begin
            phase[i] <= PH_GUARD; // R11
            cnt[i] <= {1'b0, timing[i].guard}; // R19
            side_prev[i] <= m[1];
          end else begin
            phase[i] <= PH_CHARGE; // R14 R5
            cnt[i] <= 9'(timing[i].blank) + 9'(timing[i].filter); // R19
            on_prev[i] <= 1'b1;
            side_prev[i] <= m[1];
          end
        end else begin
          if (cnt[i] > 9'h001) begin
            cnt[i] <= cnt[i] - 9'h001;
          end else begin
            unique case (phase[i])
              PH_OFF_GUARD: phase[i] <= PH_OFF; // R17
              PH_GUARD: begin
                phase[i] <= PH_CHARGE; // R12
                cnt[i] <= 9'(timing[i].blank) + 9'(timing[i].filter); // R19
              end
              PH_CHARGE: phase[i] <= PH_HOLD; // R13
              default: phase[i] <= phase[i];
            endcase
          end
        end
      end
    end
  end

  // Gate drive outputs are registered copies of the phase decode.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `HB_COUNT; i++) begin
        high_side_switch[i] <= '{kind: GD_PASSIVE, code: 5'h00};
        low_side_switch[i] <= '{kind: GD_PASSIVE, code: 5'h00};
      end
    end else begin
      for (int i = 0; i < `HB_COUNT; i++) begin
        {high_side_switch[i], low_side_switch[i]} <=
          drive_pair(phase[i], side_prev[i], static_current_reg[i*4 +: 4], hold_current_sel);
      end
    end
  end

  // Turn-on with and without guard, as step sequences on bridge 0.
  sequence from_low_to_high_s;
    apply[0] && on_prev[0] && !side_prev[0] && (hb_mode(applied_mode, 0) == `MODE_HIGH)
      && active && !fault_hit && !pwm_channel_setup[0];
  endsequence
  sequence from_off_to_on_s;
    apply[0] && !on_prev[0] && mode_on(hb_mode(applied_mode, 0)) && active
      && !fault_hit && !pwm_channel_setup[0] && (phase[0] != PH_PASSIVE)
      && (phase[0] != PH_FAULT);
  endsequence
  sequence from_high_to_low_s;
    apply[0] && on_prev[0] && side_prev[0] && (hb_mode(applied_mode, 0) == `MODE_LOW)
      && active && !fault_hit && !pwm_channel_setup[0];
  endsequence

  mode_apply_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R15
    mode_wr |-> ##[1:APPLY_MAX] (apply[0] && (applied_mode == half_bridge_mode_reg)))
    else $error("mode command not applied in time");
  guard_first_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R11
    from_low_to_high_s |=> (phase[0] == PH_GUARD) ##1 (high_side_switch[0].kind == GD_DCHG_ST
      || phase[0] != PH_GUARD))
    else $error("guard phase skipped on side change");
  skip_guard_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R14
    from_off_to_on_s |=> (phase[0] == PH_CHARGE))
    else $error("charge did not start at once from off");
  charge_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R13
    (phase[0] == PH_CHARGE) && (cnt[0] <= 9'h001) && !apply[0] && active && !fault_hit
      |=> (phase[0] == PH_HOLD) ##1 (low_side_switch[0].kind != GD_HARD_OFF))
    else $error("hold not reached after filter time");
  // Outputs are registered: they follow the side and select of the cycle before.
  hard_off_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R7
    (phase[0] == PH_CHARGE) |=> (($past(side_prev[0]) ? low_side_switch[0].code
      : high_side_switch[0].code) == `CODE_HARD_OFF))
    else $error("hard-off code wrong");
  hold_level_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R9
    (high_side_switch[0].kind == GD_HOLD_ON) |->
      (high_side_switch[0].code == ($past(hold_current_sel) ? `CODE_HOLD_HI : `CODE_HOLD_LO)))
    else $error("hold level code wrong");
  fault_off_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R10
    fault_hit |=> (phase[0] == PH_FAULT) ##1 (low_side_switch[0].kind == GD_DCHG_ST))
    else $error("fault did not force static discharge");
  passive_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R6
    !active [*2] |=> (high_side_switch[0].kind == GD_PASSIVE))
    else $error("gate driven while not active");
  off_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R17
    (phase[0] == PH_OFF) |=> (high_side_switch[0].kind == GD_HOLD_OFF)
      && (low_side_switch[0].kind == GD_HOLD_OFF))
    else $error("off bridge not held off");
  static_code_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R8
    (phase[0] == PH_CHARGE) && $stable(static_current_reg) |=>
      ($past(static_current_reg[3:0]) == ($past(side_prev[0]) ? high_side_switch[0].code[3:0]
        : low_side_switch[0].code[3:0])))
    else $error("static current code not used");
  pwm_mapped_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R5
    apply[0] && mode_on(hb_mode(applied_mode, 0)) && !pwm_channel_setup[0] && active
      && !fault_hit |=> (phase[0] != PH_PWM))
    else $error("unmapped bridge not static");

  // Mirror of the guarded turn-on, for the low side.
  low_guard_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R16
    from_high_to_low_s |=> (phase[0] == PH_GUARD)
      ##1 (low_side_switch[0].kind == GD_DCHG_ST))
    else $error("low-side guard phase skipped");
  // Off and reserved codes both start with the static discharge guard.
  off_write_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R17
    apply[0] && (hb_mode(applied_mode, 0) == `MODE_OFF) && active && !fault_hit
      |=> (phase[0] == PH_OFF_GUARD))
    else $error("off write did not start the guard");
  reserved_off_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R4
    apply[0] && (hb_mode(applied_mode, 0) == `MODE_RSVD) && active && !fault_hit
      |=> (phase[0] == PH_OFF_GUARD))
    else $error("reserved code not treated as off");
  // In hold the selected side is held on and the other one held off.
  hold_high_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R3
    (phase[0] == PH_HOLD) && side_prev[0] |=> (high_side_switch[0].kind == GD_HOLD_ON)
      && (low_side_switch[0].kind == GD_HOLD_OFF))
    else $error("high side not held on");
  hold_low_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R2
    (phase[0] == PH_HOLD) && !side_prev[0] |=> (low_side_switch[0].kind == GD_HOLD_ON)
      && (high_side_switch[0].kind == GD_HOLD_OFF))
    else $error("low side not held on");
endmodule : half_bridge_static_gate_sequencer

/* File: tb/gate_bridge_model.sv */
`timescale 1ns/1ps
module gate_bridge_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire hb_seq_pkg::gate_drive_t [3:0] high_side_switch,
  input wire hb_seq_pkg::gate_drive_t [3:0] low_side_switch,
  input wire logic [3:0] short_hs,
  input wire hb_seq_pkg::fault_t ext_faults,
  output hb_seq_pkg::fault_t faults,
  output logic shoot_through
);
  import hb_seq_pkg::*;
  logic [3:0] hs_on;
  logic [3:0] ls_on;
  logic vds_seen;

  // A switch conducts while its gate is charged or held on.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hs_on[i] = high_side_switch[i].kind inside {GD_CHG_ST, GD_HOLD_ON};
      ls_on[i] = low_side_switch[i].kind inside {GD_CHG_ST, GD_HOLD_ON};
    end
  end

  // The comparator is latched until the short goes, standing in for a fault filter.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      vds_seen <= 1'b0;
      shoot_through <= 1'b0;
    end else begin
      if (short_hs == 4'h0) begin
        vds_seen <= 1'b0;
      end else if (|(short_hs & hs_on)) begin
        vds_seen <= 1'b1;
      end
      if (|(hs_on & ls_on)) begin
        shoot_through <= 1'b1;
      end
    end
  end

  // Only the drain-source bit comes from the bridge; the rest is the bench's.
  assign faults = ext_faults | fault_t'({2'b00, vds_seen, 2'b00});
endmodule : gate_bridge_model

/* File: tb/half_bridge_static_gate_sequencer_tb.sv */
`timescale 1ns/1ps
`include "hb_seq_params.svh"
module half_bridge_static_gate_sequencer_tb;
  import hb_seq_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic enable_in = 1'b0;
  fault_t faults;
  fault_t ext_faults = '0;
  logic [3:0] short_hs = 4'h0;
  gate_drive_t [3:0] high_side_switch;
  gate_drive_t [3:0] low_side_switch;
  logic shoot_through;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  half_bridge_static_gate_sequencer DUT (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enable_in(enable_in), .faults(faults),
    .high_side_switch(high_side_switch), .low_side_switch(low_side_switch));

  gate_bridge_model bridges (.sys_clk(sys_clk), .resetn(resetn),
    .high_side_switch(high_side_switch), .low_side_switch(low_side_switch),
    .short_hs(short_hs), .ext_faults(ext_faults), .faults(faults),
    .shoot_through(shoot_through));

  // 40 MHz clock.
  always #12.5 sys_clk = ~sys_clk;

  // A hang counts as a mismatch; the whole run needs well under this.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_errors = n_errors + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; outputs are read before the edge's own updates land.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the bench timeout bounds this wait; the slave sets its own pace.
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  task automatic chk_hb(input int i, input drive_kind_t hk, input logic [4:0] hc,
                        input drive_kind_t lk, input logic [4:0] lc);
    check({24'h0, high_side_switch[i]}, {24'h0, hk, hc});
    check({24'h0, low_side_switch[i]}, {24'h0, lk, lc});
  endtask : chk_hb

  task automatic chk_passive(input int i);
    check({29'h0, high_side_switch[i].kind}, {29'h0, GD_PASSIVE});
    check({29'h0, low_side_switch[i].kind}, {29'h0, GD_PASSIVE});
  endtask : chk_passive

  // Switch-over from the opposite on-mode: guard, charge with hard-off, hold.
  task automatic guarded(input logic [1:0] m, input logic [4:0] h);
    wr(`ADDR_MODE, {30'h0, m});
    cyc(3);
    chk_hb(0, GD_DCHG_ST, 5'h05, GD_DCHG_ST, 5'h05);
    cyc(3);
    if (m == `MODE_HIGH) chk_hb(0, GD_CHG_ST, 5'h05, GD_HARD_OFF, `CODE_HARD_OFF);
    else chk_hb(0, GD_HARD_OFF, `CODE_HARD_OFF, GD_CHG_ST, 5'h05);
    cyc(4);
    if (m == `MODE_HIGH) chk_hb(0, GD_HOLD_ON, h, GD_HOLD_OFF, h);
    else chk_hb(0, GD_HOLD_OFF, h, GD_HOLD_ON, h);
  endtask : guarded

  // Main sequence; bridges 0 and 1 use guard 3, blank 2, filter 2.
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    enable_in <= 1'b1;
    @(posedge sys_clk);
    chk_passive(0);
    apb(1'b0, `ADDR_CTRL, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, `ADDR_MODE, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `ADDR_STICHG, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    check({31'h0, err}, 32'h1);
    wr(`ADDR_TIM0, 32'h0002_0203);
    apb(1'b0, `ADDR_TIM0, 32'h0);
    check(rd, 32'h0002_0203);
    wr(`ADDR_TIM0 + 8'h04, 32'h0002_0203);
    wr(`ADDR_STICHG, 32'h0000_00F5);
    wr(`ADDR_MODE, 32'h2);
    cyc(4);
    chk_passive(0);
    wr(`ADDR_MODE, 32'h0);
    wr(`ADDR_CTRL, 32'h0);
    cyc(10);
    chk_hb(0, GD_HOLD_OFF, `CODE_HOLD_LO, GD_HOLD_OFF, `CODE_HOLD_LO);
    wr(`ADDR_MODE, 32'h2);
    cyc(3);
    chk_hb(0, GD_CHG_ST, 5'h05, GD_HARD_OFF, `CODE_HARD_OFF);
    cyc(4);
    chk_hb(0, GD_HOLD_ON, `CODE_HOLD_LO, GD_HOLD_OFF, `CODE_HOLD_LO);
    wr(`ADDR_CTRL, 32'h2);
    guarded(`MODE_LOW, `CODE_HOLD_HI);
    guarded(`MODE_HIGH, `CODE_HOLD_HI);
    for (int k = 0; k < 2; k++) begin
      wr(`ADDR_MODE, (k == 0) ? 32'h0 : 32'h3);
      cyc(3);
      chk_hb(0, GD_DCHG_ST, 5'h05, GD_DCHG_ST, 5'h05);
      cyc(3);
      chk_hb(0, GD_HOLD_OFF, `CODE_HOLD_HI, GD_HOLD_OFF, `CODE_HOLD_HI);
      wr(`ADDR_MODE, 32'h2);
      cyc(8);
    end
    wr(`ADDR_PWMMAP, 32'h4);
    wr(`ADDR_MODE, 32'h2A);
    cyc(3);
    chk_hb(1, GD_CHG_ST, 5'h0F, GD_HARD_OFF, `CODE_HARD_OFF);
    check({29'h0, high_side_switch[2].kind}, {29'h0, GD_PWM});
    chk_hb(0, GD_HOLD_ON, `CODE_HOLD_HI, GD_HOLD_OFF, `CODE_HOLD_HI);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) short_hs <= 4'h1;
      else ext_faults <= fault_t'(5'h10 >> i);
      cyc(4);
      chk_hb(0, GD_DCHG_ST, 5'h05, GD_DCHG_ST, 5'h05);
      ext_faults <= '0;
      short_hs <= 4'h0;
      cyc(10);
    end
    ext_faults <= fault_t'(5'h01);
    cyc(4);
    chk_hb(0, GD_HOLD_ON, `CODE_HOLD_HI, GD_HOLD_OFF, `CODE_HOLD_HI);
    wr(`ADDR_CTRL, 32'h6);
    cyc(3);
    chk_hb(0, GD_DCHG_ST, 5'h05, GD_DCHG_ST, 5'h05);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    check(rd, 32'h0000_3DB6);
    ext_faults <= '0;
    cyc(10);
    enable_in <= 1'b0;
    cyc(4);
    chk_passive(0);
    check({31'h0, shoot_through}, 32'h0);
    finish_test();
  end
endmodule : half_bridge_static_gate_sequencer_tb
